/* shared/tws_params.svh */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// Data bits in one byte on the wire
`define TWS_BYTE_BITS 4'h8
// Address bits compared against the programmed address
`define TWS_ADDR_BITS 4'h7
// Match count that means the device is addressed
`define TWS_MATCH_FULL 3'h7
// Reset value of the address buffer
`define TWS_ADDR_RESET 8'h00
// Reset value of the shift register (contents are meaningless)
`define TWS_SHIFT_RESET 8'h00
// Received address that is the general call
`define TWS_GEN_CALL 7'h00
// Default depth and width of the receive FIFO
`define TWS_FIFO_DEPTH 32
`define TWS_FIFO_WIDTH 8
`endif

/* shared/tws_pkg.sv */
package tws_pkg;
  // Phases of the serial engine, one-hot
  typedef enum logic [4:0] {
    TWS_IDLE    = 5'b00001,
    TWS_ADDR    = 5'b00010,
    TWS_DATA    = 5'b00100,
    TWS_ACK     = 5'b01000,
    TWS_STRETCH = 5'b10000
  } tws_phase_t;

  // Sampled line levels from the pins
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_lines_t;

  // Open-drain pull-down enables toward the pins
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tws_drive_t;

  // Status bits seen by software
  typedef struct packed {
    logic done;
    logic start;
    logic master_ack;
  } tws_status_t;

  // Control bits written by software
  typedef struct packed {
    logic enable;
    logic irq_enable;
    logic tx_select;
    logic no_ack;
  } tws_ctrl_t;
endpackage : tws_pkg

/* hw/tws_slave_receiver.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"

// Receive FIFO between the serial engine and the consumer
module tws_fifo #(
  parameter int WIDTH = `TWS_FIFO_WIDTH,
  parameter int DEPTH = `TWS_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } tws_fifo_state_t;

  tws_fifo_state_t st_ff;
  tws_fifo_state_t nxt_st;
  logic push; // Accepted write this cycle
  logic pop; // Accepted read this cycle

  // Honest flags straight from the fill count
  assign o_in_ready = (st_ff.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st_ff.count != '0);
  assign o_out_data = st_ff.mem[st_ff.rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Next state: pointers wrap at DEPTH, count tracks both sides
  always_comb
  begin
    nxt_st = st_ff;
    if (i_clear)
    begin
      // Disabling the unit drops any queued bytes
      nxt_st.wr_ptr = '0;
      nxt_st.rd_ptr = '0;
      nxt_st.count = '0;
    end
    else
    begin
      if (push)
      begin
        nxt_st.mem[st_ff.wr_ptr] = i_in_data;
        nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH-1)) ? '0 : st_ff.wr_ptr + 1'b1;
      end
      if (pop)
      begin
        nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH-1)) ? '0 : st_ff.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        nxt_st.count = st_ff.count + 1'b1;
      end
      else if (pop && !push)
      begin
        nxt_st.count = st_ff.count - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : tws_fifo

module tws_slave_receiver
  import tws_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire tws_pkg::tws_lines_t i_lines,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_port_select,
  input wire tws_pkg::tws_ctrl_t i_ctrl,
  input wire logic i_addr_wr,
  input wire logic i_data_wr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_data_rd,
  input wire logic i_status_rd,
  input wire logic i_scl_release_wr,
  input wire logic i_scl_release_bit,
  output logic [7:0] o_data,
  output tws_pkg::tws_status_t o_status,
  output logic o_irq,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [7:0] o_rx_data
);
  import tws_pkg::*;

  // Entire engine state in one record
  typedef struct packed {
    tws_lines_t sync1;
    tws_lines_t sync2;
    tws_lines_t prev;
    tws_phase_t phase;
    logic [7:0] addr_buf;
    logic [7:0] shift;
    logic tx_bit; // Bit shown on SDA, moves only while SCL is low
    logic [3:0] bit_cnt;
    logic [2:0] match_cnt;
    logic addressed;
    logic sda_low;
    logic scl_low;
    logic clear_armed;
    tws_status_t status;
  } tws_state_t;

  tws_state_t st_ff;
  tws_state_t nxt_st;
  logic scl_rise; // Sampled SCL rising edge
  logic scl_fall; // Sampled SCL falling edge
  logic start_seen; // Start condition on the lines
  logic stop_seen; // Stop condition on the lines
  logic fifo_ready; // FIFO can take a byte
  logic fifo_push; // Received data byte into FIFO
  logic data_access; // Software touched the data register
  logic gen_call; // Received address is all zero
  logic tx_bit_low; // Transmit bit that needs a pull-down

  // Edges come from the second sync stage and its delayed copy only
  assign scl_rise = st_ff.sync2.scl && !st_ff.prev.scl;
  assign scl_fall = !st_ff.sync2.scl && st_ff.prev.scl;
  // Data edge while clock stays high marks start or stop
  assign start_seen = st_ff.sync2.scl && st_ff.prev.scl
    && !st_ff.sync2.sda && st_ff.prev.sda;
  assign stop_seen = st_ff.sync2.scl && st_ff.prev.scl
    && st_ff.sync2.sda && !st_ff.prev.sda;
  assign data_access = i_data_rd || i_data_wr;
  assign gen_call = (st_ff.shift[7:1] == `TWS_GEN_CALL);
  // Transmit data sits MSB first in the shifter; the pin copy is held
  // through SCL high so a shift never looks like a start or stop
  assign tx_bit_low = i_ctrl.tx_select && !st_ff.tx_bit
    && (st_ff.phase == TWS_DATA) && !st_ff.status.start;

  // Open-drain pins only ever pull low; both levels are fixed at zero
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = st_ff.scl_low;
  assign o_sda_oe = st_ff.sda_low || tx_bit_low;
  assign o_port_select = i_ctrl.enable;
  assign o_data = st_ff.shift;
  assign o_status = st_ff.status;
  // Done only rises on a matched or general call address or data after one, so start
  // and address acceptance are already folded into the flag
  assign o_irq = st_ff.status.done && i_ctrl.irq_enable;

  // Received data bytes go to the consumer on the ninth clock's falling edge
  // A byte held back by a full FIFO is offered again until room appears
  assign fifo_push = (st_ff.phase == TWS_ACK) && (scl_fall || st_ff.scl_low)
    && !i_ctrl.tx_select && !st_ff.status.start;

  tws_fifo #(
    .WIDTH(`TWS_FIFO_WIDTH),
    .DEPTH(`TWS_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_clear(!i_ctrl.enable),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_ready),
    .i_in_data(st_ff.shift),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_data)
  );

  // Next-state logic of the serial engine
  always_comb
  begin
    nxt_st = st_ff;
    // Two flops per pin before anything looks at the lines
    nxt_st.sync1 = i_lines;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
    // Track the shifter MSB only while the synced clock is low
    if (!st_ff.sync2.scl)
    begin
      nxt_st.tx_bit = st_ff.shift[7];
    end

    // Software writes go to the buffer or straight to the shifter
    if (i_addr_wr)
    begin
      nxt_st.addr_buf = i_wr_data;
    end
    if (i_data_wr)
    begin
      // Not buffered: a write mid-byte corrupts the transfer
      nxt_st.shift = i_wr_data;
    end

    // Two-step clear: status read arms, data access clears
    if (i_status_rd && (st_ff.status != '0))
    begin
      nxt_st.clear_armed = 1'b1;
    end
    else if (data_access && st_ff.clear_armed)
    begin
      nxt_st.clear_armed = 1'b0;
      nxt_st.status = '0;
    end

    if (!i_ctrl.enable)
    begin
      // Disabled: abort, drop pins, clear flags; address buffer and shifter keep contents
      nxt_st.phase = TWS_IDLE;
      nxt_st.status = '0;
      nxt_st.clear_armed = 1'b0;
      nxt_st.sda_low = 1'b0;
      nxt_st.scl_low = 1'b0;
      nxt_st.addressed = 1'b0;
    end
    else if (start_seen)
    begin
      // Every start opens an address phase, even mid-data
      nxt_st.phase = TWS_ADDR;
      nxt_st.shift = st_ff.addr_buf;
      nxt_st.bit_cnt = '0;
      nxt_st.match_cnt = '0;
      nxt_st.status.start = 1'b1;
      nxt_st.sda_low = 1'b0;
      nxt_st.scl_low = 1'b0;
      nxt_st.addressed = 1'b0;
    end
    else if (stop_seen)
    begin
      // Back to idle; status flags keep their values
      nxt_st.phase = TWS_IDLE;
      nxt_st.sda_low = 1'b0;
      nxt_st.addressed = 1'b0;
    end
    else
    begin
      unique case (st_ff.phase)
        TWS_IDLE:
        begin
          // Clock input disabled: every pulse is ignored
          nxt_st.bit_cnt = '0;
        end
        TWS_ADDR, TWS_DATA:
        begin
          if (scl_rise && (st_ff.bit_cnt < `TWS_BYTE_BITS))
          begin
            // Same shifter receives and transmits
            nxt_st.shift = {st_ff.shift[6:0], st_ff.sync2.sda};
            nxt_st.bit_cnt = st_ff.bit_cnt + 1'b1;
            if ((st_ff.phase == TWS_ADDR) && (st_ff.bit_cnt < `TWS_ADDR_BITS)
              && (st_ff.shift[7] == st_ff.sync2.sda))
            begin
              nxt_st.match_cnt = st_ff.match_cnt + 1'b1;
            end
          end
          else if (scl_fall && (st_ff.bit_cnt == `TWS_BYTE_BITS))
          begin
            // Shifter is frozen from here until the next byte
            if ((st_ff.phase == TWS_ADDR)
              && (st_ff.match_cnt != `TWS_MATCH_FULL) && !gen_call)
            begin
              // Not ours: drop out until the next start
              nxt_st.phase = TWS_IDLE;
              nxt_st.status.start = 1'b0;
              nxt_st.status.done = 1'b0;
            end
            else
            begin
              // Ack address always, data only when receiving with no_ack clear
              nxt_st.phase = TWS_ACK;
              if (st_ff.phase == TWS_ADDR)
              begin
                nxt_st.addressed = 1'b1;
              end
              nxt_st.sda_low = (st_ff.phase == TWS_ADDR)
                || (!i_ctrl.tx_select && !i_ctrl.no_ack);
            end
          end
        end
        TWS_ACK:
        begin
          if (scl_rise && i_ctrl.tx_select && !st_ff.status.start)
          begin
            // Master pulls SDA low to ask for more
            nxt_st.status.master_ack = !st_ff.sync2.sda;
          end
          else if (scl_fall && (fifo_ready || i_ctrl.tx_select || st_ff.status.start))
          begin
            // Ninth clock over: free data, hold clock
            nxt_st.sda_low = 1'b0;
            nxt_st.scl_low = 1'b1;
            nxt_st.status.done = 1'b1;
            nxt_st.phase = TWS_STRETCH;
          end
          else if (scl_fall)
          begin
            // FIFO full: free data, hold the clock, set no flag for now
            nxt_st.sda_low = 1'b0;
            nxt_st.scl_low = 1'b1;
          end
          else if (st_ff.scl_low && fifo_ready)
          begin
            // Room appeared while held: finish the ninth clock
            nxt_st.sda_low = 1'b0;
            nxt_st.status.done = 1'b1;
            nxt_st.phase = TWS_STRETCH;
          end
        end
        TWS_STRETCH:
        begin
          if (i_scl_release_wr && !i_scl_release_bit)
          begin
            // Later bytes are data regardless of the match count
            nxt_st.scl_low = 1'b0;
            nxt_st.phase = TWS_DATA;
            nxt_st.bit_cnt = '0;
            nxt_st.status.start = 1'b0;
          end
        end
        default:
        begin
          nxt_st.phase = TWS_IDLE;
        end
      endcase
    end
  end

  // State register; shifter reset value is arbitrary to software
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_ff <= '{
        sync1: '{scl: 1'b1, sda: 1'b1},
        sync2: '{scl: 1'b1, sda: 1'b1},
        prev: '{scl: 1'b1, sda: 1'b1},
        phase: TWS_IDLE,
        addr_buf: `TWS_ADDR_RESET,
        shift: `TWS_SHIFT_RESET,
        tx_bit: 1'b1,
        bit_cnt: 4'h0,
        match_cnt: 3'h0,
        addressed: 1'b0,
        sda_low: 1'b0,
        scl_low: 1'b0,
        clear_armed: 1'b0,
        status: '0
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : tws_slave_receiver
`default_nettype wire

/* sim/tws_slave_receiver_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the slave receiver, bound beside every instance
module tws_slave_receiver_props
  import tws_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire tws_pkg::tws_lines_t i_lines,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_port_select,
  input wire tws_pkg::tws_ctrl_t i_ctrl,
  input wire logic i_data_rd,
  input wire logic i_status_rd,
  input wire logic i_scl_release_wr,
  input wire logic i_scl_release_bit,
  input wire tws_pkg::tws_status_t o_status,
  input wire logic o_irq,
  input wire logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic [7:0] o_rx_data
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Clearing takes two steps: a status read then a data read must clear
  sequence s_arm;
    i_status_rd && o_status.done;
  endsequence
  sequence s_access;
    i_data_rd && !i_status_rd;
  endsequence
  property p_clear;
    s_arm ##[1:2] s_access |=> !o_status.done;
  endproperty
  a_clear: assert property (p_clear) else $error("flag survived clear");
  property p_release;
    i_scl_release_wr && !i_scl_release_bit |-> ##2 !o_scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("clock still held");
  // Writing a one to the release bit must leave the stretch in place
  property p_hold;
    i_scl_release_wr && i_scl_release_bit && o_scl_oe && i_ctrl.enable |=> o_scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("clock freed by a one");
  property p_disable;
    !i_ctrl.enable |-> ##2 o_status == 3'h0 && !o_scl_oe;
  endproperty
  a_disable: assert property (p_disable) else $error("disable left state");
  property p_port;
    o_port_select == i_ctrl.enable;
  endproperty
  a_port: assert property (p_port) else $error("pin owner wrong");
  property p_irq;
    o_irq == (o_status.done && i_ctrl.irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_ack_off;
    $rose(o_scl_oe) |-> !o_sda_oe;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("data held in stretch");
  property p_done_hold;
    $rose(o_status.done) |-> o_scl_oe;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("flag without stretch");
  // Two sync stages plus compare give a few cycles of slack
  property p_start;
    $fell(i_lines.sda) && i_lines.scl && i_ctrl.enable |-> ##[1:6] o_status.start;
  endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_rx;
    o_rx_valid && !i_rx_ready && i_ctrl.enable |=> o_rx_valid && $stable(o_rx_data);
  endproperty
  a_rx: assert property (p_rx) else $error("stalled byte lost");
endmodule : tws_slave_receiver_props

bind tws_slave_receiver tws_slave_receiver_props u_props (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_lines(i_lines), .o_scl_oe(o_scl_oe),
  .o_sda_oe(o_sda_oe), .o_port_select(o_port_select), .i_ctrl(i_ctrl),
  .i_data_rd(i_data_rd), .i_status_rd(i_status_rd), .i_scl_release_wr(i_scl_release_wr),
  .i_scl_release_bit(i_scl_release_bit), .o_status(o_status), .o_irq(o_irq),
  .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready), .o_rx_data(o_rx_data)
);
`default_nettype wire

/* sim/tws_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus master: only pulls lines low, pull-ups give the high level
module tws_master_model (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_pd,
  output logic o_sda_pd,
  output logic o_hung
);
  initial
  begin
    o_scl_pd = 1'b0;
    o_sda_pd = 1'b0;
    o_hung = 1'b0;
  end
  // Honour stretching, but give up so a stuck slave cannot hang the run
  task automatic wait_high();
    int n;
    n = 0;
    while (!i_scl && n < 3000)
    begin
      #100 n++;
    end
    if (!i_scl)
      o_hung = 1'b1;
  endtask : wait_high
  task automatic start_c();
    o_sda_pd = 1'b0;
    #300 o_scl_pd = 1'b0;
    wait_high();
    #400 o_sda_pd = 1'b1;
    #400 o_scl_pd = 1'b1;
    #200;
  endtask : start_c
  task automatic stop_c();
    o_sda_pd = 1'b1;
    #300 o_scl_pd = 1'b0;
    wait_high();
    #400 o_sda_pd = 1'b0;
    #400;
  endtask : stop_c
  // Nine clocks, 800 ns each; data moves only while SCL is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    o_scl_pd = 1'b1;
    #200;
    for (int i = 8; i >= 0; i--)
    begin
      o_sda_pd = !d[i];
      #300 o_scl_pd = 1'b0;
      wait_high();
      #150 q[i] = i_sda;
      #150 o_scl_pd = 1'b1;
      #200;
    end
  endtask : xfer
endmodule : tws_master_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tws_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic rdy = 1'b0;
  logic rel = 1'b0;
  logic [4:0] stb = 5'h00; // addr_wr, data_wr, release_wr, data_rd, status_rd
  logic [7:0] wd = 8'h00;
  tws_ctrl_t ctrl = 4'h0;
  logic scl_oe, sda_oe, ps, irq, rv, scl_pd, sda_pd, hung;
  logic [7:0] dat, rd;
  tws_status_t st;
  tws_lines_t lines;
  int num_errors = 0;
  int checks = 0;
  logic [8:0] q;
  logic [7:0] exp_q[$];
  logic [6:0] addr;
  // Wired-AND bus with pull-ups
  assign lines.scl = !(scl_pd | scl_oe);
  assign lines.sda = !(sda_pd | sda_oe);
  always #50 i_clock = !i_clock;
  tws_slave_receiver uut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_lines(lines), .o_scl(), .o_scl_oe(scl_oe),
    .o_sda(), .o_sda_oe(sda_oe), .o_port_select(ps), .i_ctrl(ctrl), .i_addr_wr(stb[4]),
    .i_data_wr(stb[3]), .i_wr_data(wd), .i_data_rd(stb[1]), .i_status_rd(stb[0]),
    .i_scl_release_wr(stb[2]), .i_scl_release_bit(rel), .o_data(dat), .o_status(st),
    .o_irq(irq), .o_rx_valid(rv), .i_rx_ready(rdy), .o_rx_data(rd)
  );
  tws_master_model m (
    .i_scl(lines.scl), .i_sda(lines.sda), .o_scl_pd(scl_pd), .o_sda_pd(sda_pd), .o_hung(hung)
  );
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge hung)
  begin
    num_errors++;
    final_report();
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task automatic pulse(input logic [4:0] v);
    @(posedge i_clock);
    #1 stb = v;
    @(posedge i_clock);
    #1 stb = 5'h00;
  endtask : pulse
  // Bounded wait; a wrong outcome ends the run
  task automatic wait_done(input logic exp);
    int n;
    n = 0;
    while (st.done !== 1'b1 && n < 40)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk(st.done, exp);
    if (st.done !== exp)
      final_report();
  endtask : wait_done
  // Software service: flag, clear by status then data read, release clock
  task automatic svc(input logic [8:0] e, input bit dd);
    wait_done(1'b1);
    chk({irq, scl_oe, sda_oe}, {ctrl.irq_enable, 2'b10});
    if (dd)
      chk(dat, e);
    pulse(5'h01);
    pulse(5'h02);
    #100 chk(st.done, 1'b0);
    rel = 1'b1;
    pulse(5'h04);
    #100 chk(scl_oe, 1'b1);
    rel = 1'b0;
    pulse(5'h04);
    #100 chk(scl_oe, 1'b0);
  endtask : svc
  task automatic pop_one();
    chk({rv, rd}, {1'b1, exp_q.pop_front()});
    @(posedge i_clock);
    #1 rdy = 1'b1;
    @(posedge i_clock);
    #1 rdy = 1'b0;
  endtask : pop_one
  initial
  begin
    wd = 8'($urandom(32'h6000));
    repeat (3) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    chk({st, irq, scl_oe, sda_oe, ps}, 9'h000);
    // At least two bits set, so a one-bit flip never becomes the general call
    addr = 7'($urandom_range(126, 1)) | 7'h03;
    wd = {addr, 1'b0};
    pulse(5'h10);
    ctrl = 4'b1100;
    #100 chk(ps, 1'b1);
    m.start_c();
    m.xfer({addr, 2'b01}, q);
    chk({q[0], st.start}, 2'b01);
    svc({1'b0, addr, 1'b0}, 1'b1);
    // Fill the FIFO with the consumer stalled; byte 33 finds it full
    for (int i = 0; i < 33; i++)
    begin
      wd = 8'($urandom);
      m.xfer({wd, 1'b1}, q);
      chk(q[0], 1'b0);
      exp_q.push_back(wd);
      if (i == 32)
      begin
        wait_done(1'b0);
        chk({scl_oe, sda_oe}, 2'b10);
        pop_one();
      end
      svc({1'b0, wd}, 1'b1);
    end
    while (exp_q.size() > 0)
      pop_one();
    #100 chk(rv, 1'b0);
    // Every single wrong address bit is refused
    for (int b = 0; b < 7; b++)
    begin
      m.start_c();
      m.xfer({addr ^ (7'h01 << b), 2'b01}, q);
      chk(q[0], 1'b1);
      wait_done(1'b0);
      chk({st.start, scl_oe}, 2'b00);
    end
    m.xfer(9'h0ab, q);
    chk(q[0], 1'b1);
    m.start_c();
    m.xfer(9'h001, q);
    chk(q[0], 1'b0);
    svc(9'h000, 1'b1);
    m.start_c();
    m.xfer({addr, 2'b11}, q);
    chk(q[0], 1'b0);
    svc({1'b0, addr, 1'b1}, 1'b1);
    wd = 8'($urandom);
    ctrl = 4'b1110;
    pulse(5'h08);
    m.xfer(9'h1fe, q);
    chk(q, {wd, 1'b0});
    wait_done(1'b1);
    chk(st.master_ack, 1'b1);
    svc(9'h000, 1'b0);
    ctrl = 4'b1100;
    m.stop_c();
    m.xfer(9'h14b, q);
    chk(q[0], 1'b1);
    wait_done(1'b0);
    ctrl = 4'b0000;
    #200 chk({st, ps}, 4'h0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
